// >>> src/cal_seq_regs.svh
`ifndef CAL_SEQ_REGS_SVH
`define CAL_SEQ_REGS_SVH

// Stage count and RAM layout
`define STAGE_COUNT 4'hE
`define RAM_DEPTH 8'h40
`define HDR_WORDS 8'h08
`define BTP_ZERO_LO 8'h00
`define BTP_ONE_LO 8'h08
`define MTP_X_LO 8'h10
`define MTP_Y_LO 8'h18
`define MTP_F5_LO 8'h20
`define MTP_F5_HI 8'h27
// Field positions of a memory word record
`define BEAT_W 4
// Timing
`define PWRUP_NS 200000
`define CLK_NS 50
`define PWRUP_CYC ((`PWRUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC 16'h0010
`define SWEEP_STEPS 8'h10
`define HDR_VERSION 32'h00010000
// Mode register override bits
`define MR_DLL_EN_BIT 0
`define MR_BL4 3'h2
`define MR_OCD_BIT 7
`define MR3_QOFF_BIT 12
`define MR3_WLEV_BIT 7
`define MR3_DLLRST_BIT 8
`define MR3_TM_BIT 7
`define MR3_BLOTF 2'h1

`endif

// >>> src/cal_seq_pkg.sv
package cal_seq_pkg;
    typedef enum logic [3:0] {
        ST_RESET     = 4'h0,
        ST_PHY_INIT  = 4'h1,
        ST_PWRUP     = 4'h2,
        ST_MODE_PROG = 4'h3,
        ST_HDR       = 4'h4,
        ST_BTP       = 4'h5,
        ST_MTP       = 4'h6,
        ST_PROBE     = 4'h7,
        ST_DONE      = 4'h8,
        ST_FAIL      = 4'h9
    } stage_t;
    typedef enum logic [1:0] {
        MEM_DDR  = 2'h0,
        MEM_DDR2 = 2'h1,
        MEM_DDR3 = 2'h2
    } mem_kind_t;
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_MRS = 3'h1,
        CMD_ZQCL = 3'h2,
        CMD_WR = 3'h3,
        CMD_RD = 3'h4,
        CMD_PRE = 3'h5,
        CMD_CKE = 3'h6
    } cmd_t;
endpackage

// >>> src/window_meter.sv
`timescale 1ns/1ps
`include "cal_seq_regs.svh"

// Counts the longest run of matching phase steps; reports size only.
module window_meter
    import cal_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic hit,
    output logic [7:0] best
);
    logic [7:0] run_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 8'h00;
            best <= 8'h00;
        end else if (clear) begin
            run_r <= 8'h00;
            best <= 8'h00;
        end else if (step) begin
            run_r <= hit ? run_r + 8'h01 : 8'h00;
            if (hit && (run_r + 8'h01) > best) begin
                best <= run_r + 8'h01;
            end
        end
    end
endmodule

// >>> src/cal_sequencer.sv
`timescale 1ns/1ps
`include "cal_seq_regs.svh"

// Operation
// - Stages run in one fixed nine-step order
// - Start after reset release, request low
// - Wait DLL lock; debug clears RAM
// - Power-up sequence stops before mode sets
// - Power-up drives all chip selects together
// - Mode sets per rank, then refresh
// - DDR/DDR2 force DLL, BL4; DDR2 also OCD
// - DDR3 forces DLL, Qoff, WL, OTF, TM, reset
// - DDR3 issues long ZQ calibration
// - Header fills first eight RAM words
// - Block write: steady outputs, toggling strobe
// - Zeros at 7..0, ones at 15..8
// - Extended pattern from separate nibbles
// - X at 23..16, Y 31..24, F5 39..32
// - Four-beat bursts; F and 0 earlier
// - Write 0011 to X, 1100 to Y
// - Two single-pin sweeps, X then Y
// - Window calc reports size only
// - Assume BL4, no leveling, cycle alignment
// - Command delay at most one, zero full-rate
// - Read alignment delay only in half-rate
// - Raise success or fail at end
// - Soft reset restarts whole calibration
module cal_sequencer
    import cal_seq_pkg::*;
#(
    parameter int PWRUP_CYCLES = `PWRUP_CYC,
    parameter int NUM_CS = 2
)
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic soft_reset_n,
    input wire logic phy_reset_done,
    input wire logic cal_req,
    input wire logic dll_locked,
    input wire logic debug_en,
    input wire logic half_rate,
    input wire logic [1:0] mem_kind,
    input wire logic [15:0] user_mr0,
    input wire logic [15:0] user_mr1,
    input wire logic rd_valid,
    input wire logic rd_dq0,
    input wire logic [7:0] ram_rd_idx,
    output logic [31:0] ram_rd_data,
    output logic [2:0] mem_cmd,
    output logic [NUM_CS-1:0] mem_cs,
    output logic [15:0] mem_addr,
    output logic [2:0] mem_ba,
    output logic double_rate_output_cell_hi,
    output logic double_rate_output_cell_lo,
    output logic dq_oe,
    output logic dqs_toggle,
    output logic refresh_en,
    output logic phase_step,
    output logic single_pin,
    output logic ac_1t,
    output logic rd_1t,
    output logic [7:0] win_x,
    output logic [7:0] win_y,
    output logic [3:0] stage_num,
    output logic cal_success,
    output logic cal_fail
);
    stage_t stage_r, stage_nxt;
    logic [31:0] ram_r [0:63];
    logic [31:0] cnt_r;
    logic [7:0] sub_r;
    logic [NUM_CS-1:0] cs_done_r;
    logic stage_done;
    logic stage_err;
    logic win_clear, win_step;
    logic [7:0] win_best;
    logic pass_y_r;

    // Collapses a memory word index into the RAM address range
    function automatic logic [5:0] ram_idx(input logic [7:0] loc);
        ram_idx = loc[5:0];
    endfunction

    // Overridden mode register value for the chosen memory kind
    function automatic logic [15:0] mr_value(input logic [1:0] kind, input logic [1:0] which,
                                             input logic [15:0] mr0, input logic [15:0] mr1);
        logic [15:0] v;
        v = (which == 2'h0) ? mr0 : mr1;
        if (kind == MEM_DDR3) begin
            if (which == 2'h0) begin
                v[1:0] = `MR3_BLOTF;
                v[`MR3_TM_BIT] = 1'b0;
                v[`MR3_DLLRST_BIT] = 1'b1;
            end else begin
                v[`MR_DLL_EN_BIT] = 1'b0;
                v[`MR3_WLEV_BIT] = 1'b0;
                v[`MR3_QOFF_BIT] = 1'b0;
            end
        end else begin
            if (which == 2'h0) begin
                v[2:0] = `MR_BL4;
            end else begin
                v[`MR_DLL_EN_BIT] = 1'b0;
                if (kind == MEM_DDR2) begin
                    v[9:7] = 3'h7;
                end
            end
        end
        mr_value = v;
    endfunction

    window_meter u_win (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clear(win_clear),
        .step(win_step),
        .hit(rd_valid && (rd_dq0 == sub_r[1])),
        .best(win_best)
    );

    // ************************************************************
    // Stage sequencing
    // ************************************************************
    always_comb begin
        stage_nxt = stage_r;
        if (stage_err && stage_r != ST_DONE && stage_r != ST_FAIL) begin
            stage_nxt = ST_FAIL;
        end else if (stage_done) begin
            case (stage_r)
                ST_RESET: stage_nxt = ST_PHY_INIT;
                ST_PHY_INIT: stage_nxt = ST_PWRUP;
                ST_PWRUP: stage_nxt = ST_MODE_PROG;
                ST_MODE_PROG: stage_nxt = ST_HDR;
                ST_HDR: stage_nxt = ST_BTP;
                ST_BTP: stage_nxt = ST_MTP;
                ST_MTP: stage_nxt = ST_PROBE;
                ST_PROBE: stage_nxt = ST_DONE;
                default: stage_nxt = stage_r;
            endcase
        end
    end

    always_comb begin
        stage_done = 1'b0;
        stage_err = 1'b0;
        case (stage_r)
            ST_RESET: stage_done = phy_reset_done && !cal_req;
            ST_PHY_INIT: stage_done = dll_locked && (!debug_en || cnt_r >= 32'h3F);
            ST_PWRUP: stage_done = (cnt_r == 32'(PWRUP_CYCLES));
            ST_MODE_PROG: stage_done = (cs_done_r == {NUM_CS{1'b1}}) && sub_r == 8'h05;
            ST_HDR: stage_done = (cnt_r == 32'({24'h0, `HDR_WORDS} - 1));
            ST_BTP: stage_done = (cnt_r == 32'({16'h0, `STROBE_CYC}) * 2);
            ST_MTP: stage_done = (cnt_r == 32'({16'h0, `STROBE_CYC}) * 3);
            ST_PROBE: begin
                stage_done = pass_y_r && sub_r == `SWEEP_STEPS;
                stage_err = !dll_locked;
            end
            default: stage_done = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_r <= ST_RESET;
        end else if (!soft_reset_n) begin
            stage_r <= ST_RESET;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    // Cycle and sub-step counters restart at each stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 32'h0;
        end else if (!soft_reset_n || stage_nxt != stage_r) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    // ************************************************************
    // Sub-step counters: mode register programming rank by rank, probe sweep steps
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sub_r <= 8'h00;
            cs_done_r <= '0;
            pass_y_r <= 1'b0;
        end else if (!soft_reset_n || stage_nxt != stage_r) begin
            sub_r <= 8'h00;
            if (stage_nxt == ST_MODE_PROG || !soft_reset_n) begin
                cs_done_r <= '0;
            end
            pass_y_r <= 1'b0;
        end else if (stage_r == ST_MODE_PROG && cs_done_r != {NUM_CS{1'b1}}) begin
            if (sub_r == 8'h03) begin
                sub_r <= 8'h00;
                cs_done_r <= {cs_done_r[NUM_CS-2:0], 1'b1};
            end else begin
                sub_r <= sub_r + 8'h01;
            end
        end else if (stage_r == ST_MODE_PROG) begin
            if (sub_r != 8'h05) begin
                sub_r <= sub_r + 8'h01;
            end
        end else if (stage_r == ST_PROBE && win_step) begin
            if (sub_r == `SWEEP_STEPS - 8'h01 && !pass_y_r) begin
                sub_r <= 8'h00;
                pass_y_r <= 1'b1;
            end else begin
                sub_r <= sub_r + 8'h01;
            end
        end
    end

    // ************************************************************
    // Memory command outputs
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_cmd <= CMD_NOP;
            mem_cs <= '0;
            mem_addr <= 16'h0;
            mem_ba <= 3'h0;
            refresh_en <= 1'b0;
        end else begin
            mem_cmd <= CMD_NOP;
            mem_cs <= '0;
            case (stage_r)
                ST_PWRUP: begin
                    mem_cs <= {NUM_CS{1'b1}};
                    mem_cmd <= (cnt_r == 32'(PWRUP_CYCLES) - 1) ? CMD_PRE : CMD_CKE;
                end
                ST_MODE_PROG: begin
                    if (cs_done_r != {NUM_CS{1'b1}}) begin
                        mem_cs <= ~cs_done_r & (cs_done_r + 1'b1);
                        if (sub_r[1] == 1'b0) begin
                            mem_cmd <= CMD_MRS;
                            mem_ba <= {2'h0, sub_r[0]};
                            mem_addr <= mr_value(mem_kind, {1'b0, sub_r[0]}, user_mr0,
                                                 user_mr1);
                        end
                    end else if (sub_r == 8'h04 && mem_kind == MEM_DDR3) begin
                        mem_cs <= {NUM_CS{1'b1}};
                        mem_cmd <= CMD_ZQCL;
                        mem_addr <= 16'h0400;
                    end else if (sub_r == 8'h04) begin
                        refresh_en <= 1'b1;
                    end
                    if (sub_r == 8'h05) begin
                        refresh_en <= 1'b1;
                    end
                end
                ST_BTP: begin
                    if (cnt_r[3:0] == 4'h8) begin
                        mem_cs <= NUM_CS'(1);
                        mem_cmd <= CMD_WR;
                        mem_addr <= {8'h0, cnt_r[4] ? `BTP_ONE_LO : `BTP_ZERO_LO};
                    end
                end
                ST_MTP: begin
                    if (cnt_r[3:0] == 4'h8) begin
                        mem_cs <= NUM_CS'(1);
                        mem_cmd <= CMD_WR;
                        mem_addr <= {8'h0, cnt_r[5] ? `MTP_F5_LO
                                    : (cnt_r[4] ? `MTP_Y_LO : `MTP_X_LO)};
                    end
                end
                ST_PROBE: begin
                    mem_cs <= NUM_CS'(1);
                    mem_cmd <= CMD_RD;
                    mem_addr <= {8'h0, pass_y_r ? `MTP_Y_LO : `MTP_X_LO};
                end
                default: mem_cmd <= CMD_NOP;
            endcase
            if (!soft_reset_n) begin
                refresh_en <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Write data path and strobe
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            double_rate_output_cell_hi <= 1'b0;
            double_rate_output_cell_lo <= 1'b0;
            dq_oe <= 1'b0;
            dqs_toggle <= 1'b0;
        end else begin
            dq_oe <= (stage_r == ST_BTP) || (stage_r == ST_MTP);
            dqs_toggle <= (stage_r == ST_BTP) || (stage_r == ST_MTP);
            if (stage_r == ST_BTP) begin
                double_rate_output_cell_hi <= (cnt_r >= 32'({16'h0, `STROBE_CYC}));
                double_rate_output_cell_lo <= (cnt_r >= 32'({16'h0, `STROBE_CYC}));
            end else if (stage_r == ST_MTP) begin
                // Stream 0011 then 1100 at controller rate; toggle nibble last
                if (cnt_r < 32'({16'h0, `STROBE_CYC}) * 2) begin
                    double_rate_output_cell_hi <= cnt_r[0] ^ cnt_r[4];
                    double_rate_output_cell_lo <= cnt_r[0] ^ cnt_r[4];
                end else begin
                    double_rate_output_cell_hi <= 1'b0;
                    double_rate_output_cell_lo <= 1'b1;
                end
            end else begin
                double_rate_output_cell_hi <= 1'b0;
                double_rate_output_cell_lo <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Internal RAM: clear, header, pattern shadow
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (stage_r == ST_PHY_INIT && debug_en) begin
            ram_r[cnt_r[5:0]] <= 32'h0;
        end else if (stage_r == ST_HDR) begin
            ram_r[cnt_r[5:0]] <= (cnt_r[2:0] == 3'h0) ? `HDR_VERSION
                                : {16'h0, 8'(NUM_CS), 6'h0, mem_kind};
        end else if (stage_r == ST_BTP && cnt_r[4:0] == 5'h18) begin
            // Zeros are not shadowed: their word would land on the header
            ram_r[ram_idx(`BTP_ONE_LO)] <= 32'hFFFFFFFF;
        end else if (stage_r == ST_MTP && cnt_r[3:0] == 4'h8) begin
            ram_r[ram_idx(cnt_r[5] ? `MTP_F5_LO
                : (cnt_r[4] ? `MTP_Y_LO : `MTP_X_LO))] <=
                cnt_r[5] ? 32'h000000F5 : {28'h0, cnt_r[4] ? 4'hC : 4'h3};
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_rd_data <= 32'h0;
        end else begin
            ram_rd_data <= ram_r[ram_idx(ram_rd_idx)];
        end
    end

    // ************************************************************
    // Single-pin sweeps and window reporting
    // ************************************************************
    assign win_clear = (stage_r != ST_PROBE) || (sub_r == 8'h00 && !win_step);
    assign win_step = (stage_r == ST_PROBE) && rd_valid;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            win_x <= 8'h00;
            win_y <= 8'h00;
            phase_step <= 1'b0;
            single_pin <= 1'b0;
            ac_1t <= 1'b0;
            rd_1t <= 1'b0;
        end else begin
            phase_step <= 1'b0;
            single_pin <= (stage_r == ST_PROBE);
            ac_1t <= half_rate;
            rd_1t <= half_rate;
            if (stage_r == ST_PROBE && !pass_y_r) begin
                win_x <= win_best;
            end else if (stage_r == ST_PROBE) begin
                win_y <= win_best;
            end
        end
    end

    // ************************************************************
    // Result flags
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_num <= 4'h0;
            cal_success <= 1'b0;
            cal_fail <= 1'b0;
        end else begin
            stage_num <= stage_r;
            cal_success <= (stage_nxt == ST_DONE) && soft_reset_n;
            cal_fail <= (stage_nxt == ST_FAIL) && soft_reset_n;
        end
    end

    chk_start_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (stage_r == ST_RESET && stage_nxt == ST_PHY_INIT) |-> (phy_reset_done && !cal_req))
        else $error("calibration started without reset release");
    chk_soft_restart: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !soft_reset_n |=> stage_r == ST_RESET)
        else $error("soft reset did not restart");
    chk_lock_wait: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (stage_r == ST_PHY_INIT && !dll_locked) |=> stage_r != ST_PWRUP)
        else $error("left init without lock");
    chk_pwrup_all_cs: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (stage_r == ST_PWRUP) |=> (mem_cs == {NUM_CS{1'b1}}) || !soft_reset_n)
        else $error("power-up not on all ranks");
    chk_refresh_late: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(refresh_en) |-> $past(cs_done_r) == {NUM_CS{1'b1}})
        else $error("refresh before all ranks set");
    chk_mrs_one_cs: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (mem_cmd == CMD_MRS) |-> $onehot(mem_cs))
        else $error("mode set on several ranks");
    chk_no_phase_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !phase_step)
        else $error("window calc moved phase");
    chk_success_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (stage_r == ST_PROBE && stage_nxt == ST_DONE && soft_reset_n) |=> cal_success)
        else $error("success flag missing");
    chk_fail_exclusive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(cal_success && cal_fail))
        else $error("both result flags high");
    chk_full_rate_1t: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !$past(half_rate) |-> !ac_1t && !rd_1t)
        else $error("1T set in full rate");
endmodule

// >>> testbench/sdram_model.sv
`timescale 1ns/1ps
// ****************
// Far side: lock report and probe read samples
// ****************
module sdram_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic lock_en,
    input wire logic drop_lock,
    input wire logic single_pin,
    output logic dll_locked,
    output logic rd_valid,
    output logic rd_dq0
);
    logic [3:0] lock_cnt_r;
    logic [3:0] samp_r;
    assign dll_locked = (lock_cnt_r == 4'hF) && !drop_lock;
    // Lock is reported only some cycles after it is allowed
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt_r <= 4'h0;
        end else if (!lock_en) begin
            lock_cnt_r <= 4'h0;
        end else if (lock_cnt_r != 4'hF) begin
            lock_cnt_r <= lock_cnt_r + 4'h1;
        end
    end
    // One sample every other cycle; outside the sweep the pin keeps toggling
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid <= 1'b0;
            rd_dq0 <= 1'b0;
            samp_r <= 4'h0;
        end else begin
            rd_valid <= single_pin && !rd_valid;
            rd_dq0 <= single_pin ? samp_r[2] : !rd_dq0;
            samp_r <= samp_r + {3'h0, single_pin && !rd_valid};
        end
    end
endmodule

// >>> testbench/ddr_phy_calibration_sequencer_bench.sv
`timescale 1ns/1ps
`include "cal_seq_regs.svh"
module ddr_phy_calibration_sequencer_bench import cal_seq_pkg::*;;
    logic ref_clk = 1'b0;
    logic arst_n, soft_reset_n, phy_reset_done, cal_req, lock_en, drop_lock;
    logic debug_en, half_rate, dll_locked, rd_valid, rd_dq0;
    logic [1:0] mem_kind;
    logic [15:0] user_mr0, user_mr1, mem_addr, mr_first;
    logic [31:0] ram_rd_data;
    logic [2:0] mem_cmd, mem_ba;
    logic [1:0] mem_cs;
    logic double_rate_output_cell_hi, double_rate_output_cell_lo, dq_oe, dqs_toggle, refresh_en, phase_step, single_pin;
    logic ac_1t, rd_1t, cal_success, cal_fail;
    logic [7:0] win_x, win_y;
    logic [7:0] rd_idx = 8'h00;
    logic [3:0] stage_num, last_st;
    logic [3:0] seen[$];
    logic [3:0] order_exp[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    int fails = 0;
    int checked = 0;
    int mrs_cnt, zq_cnt, bad_cs, mrs_pwr, ref_early, ps_bad, sp_cnt, wr_cnt, wr_bad, wsum;
    always #25 ref_clk = ~ref_clk;
    cal_sequencer #(.PWRUP_CYCLES(20), .NUM_CS(2)) dut_u (.ref_clk(ref_clk),
        .arst_n(arst_n), .soft_reset_n(soft_reset_n), .phy_reset_done(phy_reset_done),
        .cal_req(cal_req), .dll_locked(dll_locked), .debug_en(debug_en),
        .half_rate(half_rate), .mem_kind(mem_kind), .user_mr0(user_mr0),
        .user_mr1(user_mr1), .rd_valid(rd_valid), .rd_dq0(rd_dq0), .ram_rd_idx(rd_idx),
        .ram_rd_data(ram_rd_data), .mem_cmd(mem_cmd), .mem_cs(mem_cs),
        .mem_addr(mem_addr), .mem_ba(mem_ba), .double_rate_output_cell_hi(double_rate_output_cell_hi), .double_rate_output_cell_lo(double_rate_output_cell_lo),
        .dq_oe(dq_oe), .dqs_toggle(dqs_toggle), .refresh_en(refresh_en),
        .phase_step(phase_step), .single_pin(single_pin), .ac_1t(ac_1t),
        .rd_1t(rd_1t), .win_x(win_x), .win_y(win_y), .stage_num(stage_num),
        .cal_success(cal_success), .cal_fail(cal_fail));
    sdram_model mem_u (.ref_clk(ref_clk), .arst_n(arst_n), .lock_en(lock_en),
        .drop_lock(drop_lock), .single_pin(single_pin), .dll_locked(dll_locked),
        .rd_valid(rd_valid), .rd_dq0(rd_dq0));
    // ****************
    // Monitor of commands and stage order
    // ****************
    always @(negedge ref_clk) begin
        if (stage_num !== last_st) begin
            seen.push_back(stage_num);
            last_st = stage_num;
        end
        if (mem_cmd === CMD_CKE && mem_cs !== 2'h3) bad_cs++;
        if (mem_cmd === CMD_MRS) begin
            if (stage_num === ST_PWRUP) mrs_pwr++;
            if (mrs_cnt == 0) mr_first = mem_addr;
            if (!$onehot(mem_cs)) bad_cs++;
            if (refresh_en === 1'b1) ref_early++;
            mrs_cnt++;
        end
        if (mem_cmd === CMD_ZQCL) zq_cnt++;
        if (mem_cmd === CMD_WR) begin
            wr_cnt++;
            wsum += mem_addr;
            if (dq_oe !== 1'b1 || dqs_toggle !== 1'b1) wr_bad++;
            if (mem_addr === `BTP_ZERO_LO && {double_rate_output_cell_hi, double_rate_output_cell_lo} !== 2'h0) wr_bad++;
            if (mem_addr === `BTP_ONE_LO && {double_rate_output_cell_hi, double_rate_output_cell_lo} !== 2'h3) wr_bad++;
            if (mem_addr === `MTP_F5_LO && {double_rate_output_cell_hi, double_rate_output_cell_lo} !== 2'h1) wr_bad++;
        end
        if (phase_step !== 1'b0) ps_bad++;
        if (rd_valid && single_pin === 1'b1) sp_cnt++;
    end
    // ****************
    // Tasks
    // ****************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic ram_check(input string name, input logic [7:0] idx, input logic [31:0] exp);
        rd_idx = idx;
        @(posedge ref_clk);
        #5 check(name, exp, ram_rd_data);
    endtask
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run_cal(input logic [1:0] kind, input logic drop);
        @(posedge ref_clk);
        #5 soft_reset_n = 1'b0;
        mem_kind = kind;
        half_rate = kind[0];
        debug_en = kind[1];
        cal_req = 1'b1;
        lock_en = 1'b0;
        drop_lock = 1'b0;
        @(posedge ref_clk);
        #5 soft_reset_n = 1'b1;
        check("flags_clear", 32'h0, {cal_success, cal_fail});
        repeat (6) @(posedge ref_clk);
        #5 check("req_hold", ST_RESET, stage_num);
        {mrs_cnt, zq_cnt, bad_cs, mrs_pwr, ref_early, ps_bad, sp_cnt, wr_cnt, wr_bad, wsum} = '0;
        seen.delete();
        last_st = ST_RESET;
        cal_req = 1'b0;
        repeat (10) @(posedge ref_clk);
        #5 check("lock_wait", ST_PHY_INIT, stage_num);
        lock_en = 1'b1;
        for (int n = 0; n < 3000 && cal_success !== 1'b1 && cal_fail !== 1'b1; n++) begin
            @(posedge ref_clk);
            #5 if (drop && single_pin === 1'b1) drop_lock = 1'b1;
        end
        // stage_num trails the flags by one cycle, the order monitor by half more
        repeat (2) @(posedge ref_clk);
        #5;
        check("success", {31'h0, !drop}, cal_success);
        check("fail", {31'h0, drop}, cal_fail);
        if (drop) begin
            check("fail_stage", ST_FAIL, stage_num);
        end else begin
            check("order_len", 8, seen.size());
            foreach (order_exp[i]) check("order", order_exp[i], seen[i]);
            check("cke_all_cs", 0, bad_cs);
            check("mrs_in_pwrup", 0, mrs_pwr);
            check("mrs_count", 4, mrs_cnt);
            check("refresh_early", 0, ref_early);
            check("refresh_on", 1, refresh_en);
            check("zq_long", {31'h0, kind == MEM_DDR3}, zq_cnt);
            check("phase_held", 0, ps_bad);
            check("sweep_len", 1, sp_cnt >= 2 * `SWEEP_STEPS);
            check("win_x_max", 1, win_x <= `SWEEP_STEPS);
            check("win_y_max", 1, win_y <= `SWEEP_STEPS);
            check("ac_1t", half_rate, ac_1t);
            check("rd_1t", half_rate, rd_1t);
            check("wr_count", 5, wr_cnt);
            check("wr_levels", 0, wr_bad);
            check("wr_adr", `BTP_ONE_LO + `MTP_X_LO + `MTP_Y_LO + `MTP_F5_LO, wsum);
            ram_check("hdr_ver", 8'h00, `HDR_VERSION);
            ram_check("hdr_cfg", 8'h07, {16'h0, 8'h02, 6'h0, kind});
            ram_check("btp_ones", `BTP_ONE_LO, 32'hFFFFFFFF);
            ram_check("mtp_x", `MTP_X_LO, 32'h3);
            ram_check("mtp_y", `MTP_Y_LO, 32'hC);
            ram_check("mtp_f5", `MTP_F5_LO, 32'hF5);
            if (kind == MEM_DDR3) begin
                check("mr_otf", `MR3_BLOTF, mr_first[1:0]);
                check("mr_dllrst", 1, mr_first[`MR3_DLLRST_BIT]);
            end else begin
                check("mr_bl4", `MR_BL4, mr_first[2:0]);
            end
        end
    endtask
    // ****************
    // Test sequence
    // ****************
    initial begin
        {arst_n, soft_reset_n, phy_reset_done, cal_req, lock_en, drop_lock} = 6'h10;
        {debug_en, half_rate, mem_kind} = 4'h0;
        user_mr0 = 16'h0000;
        user_mr1 = 16'hFFFF;
        last_st = ST_RESET;
        repeat (2) @(posedge ref_clk);
        #5 arst_n = 1'b1;
        check("cmd_reset", CMD_NOP, mem_cmd);
        repeat (4) @(posedge ref_clk);
        #5 check("phy_rst_hold", ST_RESET, stage_num);
        phy_reset_done = 1'b1;
        for (int k = 0; k < 3; k++) run_cal(k[1:0], 1'b0);
        run_cal(MEM_DDR2, 1'b1);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end
endmodule
